/* common/sss_pkg.sv */
// constants and types shared by the stereo shutter sync block
package sss_pkg;
    localparam int unsigned CLK_HZ = 50_000_000;
    localparam int unsigned CLK_PERIOD_NS = 20;
    localparam int unsigned PERIOD_W = 20;
    localparam int unsigned NUM_RATES = 6;

    // eye indicator lead ahead of vertical sync
    localparam int unsigned EYE_LEAD_US = 1000;
    localparam int unsigned EYE_LEAD_CYC = EYE_LEAD_US * 1000 / CLK_PERIOD_NS;

    // base offset and shutter-closed window are strict lower bounds, so one cycle extra
    localparam int unsigned B_MIN_US = 500;
    localparam int unsigned B_CYC = B_MIN_US * 1000 / CLK_PERIOD_NS + 1;
    localparam int unsigned E_MIN_US = 2000;
    localparam int unsigned E_CYC = E_MIN_US * 1000 / CLK_PERIOD_NS + 1;

    // legal windows for pulse width and delta offset
    localparam int unsigned A_MIN_NS = 20_000;
    localparam int unsigned A_MAX_NS = 32_000;
    localparam int unsigned D_MIN_NS = 128_000;
    localparam int unsigned D_MAX_NS = 163_000;
    localparam int unsigned A_MIN_CYC = (A_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned A_MAX_CYC = A_MAX_NS / CLK_PERIOD_NS;
    localparam int unsigned D_MIN_CYC = (D_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned D_MAX_CYC = D_MAX_NS / CLK_PERIOD_NS;

    // displayed frame rate buckets: 98, 100, 102, 118, 120, 122 Hz
    localparam int unsigned RATE_EDGE_HZ [NUM_RATES+1] = '{96, 99, 101, 110, 119, 121, 124};
    localparam int unsigned A_NOM_NS [NUM_RATES] = '{31800, 31200, 30600, 26400, 26000, 25600};
    localparam int unsigned D_NOM_NS [NUM_RATES] =
        '{161600, 158400, 155300, 134200, 132000, 129800};
    localparam int unsigned A_NOM_CYC [NUM_RATES] = '{
        A_NOM_NS[0] / CLK_PERIOD_NS, A_NOM_NS[1] / CLK_PERIOD_NS, A_NOM_NS[2] / CLK_PERIOD_NS,
        A_NOM_NS[3] / CLK_PERIOD_NS, A_NOM_NS[4] / CLK_PERIOD_NS, A_NOM_NS[5] / CLK_PERIOD_NS};
    localparam int unsigned D_NOM_CYC [NUM_RATES] = '{
        D_NOM_NS[0] / CLK_PERIOD_NS, D_NOM_NS[1] / CLK_PERIOD_NS, D_NOM_NS[2] / CLK_PERIOD_NS,
        D_NOM_NS[3] / CLK_PERIOD_NS, D_NOM_NS[4] / CLK_PERIOD_NS, D_NOM_NS[5] / CLK_PERIOD_NS};

    typedef enum logic [1:0] {
        COL_RED = 2'b00,
        COL_GREEN = 2'b01,
        COL_BLUE = 2'b10
    } sss_colour_e;

    typedef enum logic [1:0] {
        PS_IDLE = 2'b00,
        PS_PULSE = 2'b01
    } sss_pulse_e;
endpackage

/* design/sss_rate_meter.sv */
// frame period measurement and frame rate bucket selection
`timescale 1ns/1ns
module sss_rate_meter #(
    parameter int unsigned CLK_HZ = sss_pkg::CLK_HZ,
    parameter int unsigned PW = sss_pkg::PERIOD_W
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic vsync_rise,
    output logic [PW-1:0] period,
    output logic [2:0] rate_idx,
    output logic rate_ok
);
    logic [PW-1:0] count;
    logic [sss_pkg::NUM_RATES-1:0] hit;
    logic [2:0] next_idx;

    // saturating counter; an over-long frame lands outside every bucket
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            count <= '0;
        end else if (vsync_rise) begin
            count <= '0;
        end else if (count != {PW{1'b1}}) begin
            count <= count + 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            period <= '0;
        end else if (vsync_rise) begin
            period <= count + 1'b1;
        end
    end

    genvar i;
    generate
        for (i = 0; i < sss_pkg::NUM_RATES; i++) begin : g_bucket
            localparam int unsigned P_LONG = CLK_HZ / sss_pkg::RATE_EDGE_HZ[i];
            localparam int unsigned P_SHORT = CLK_HZ / sss_pkg::RATE_EDGE_HZ[i+1];
            assign hit[i] = (period > PW'(P_SHORT)) && (period <= PW'(P_LONG));
        end
    endgenerate

    always_comb begin
        next_idx = 3'h0;
        for (int k = sss_pkg::NUM_RATES - 1; k >= 0; k--) begin
            if (hit[k]) begin
                next_idx = 3'(k);
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rate_idx <= 3'h0;
            rate_ok <= 1'b0;
        end else begin
            rate_idx <= next_idx;
            rate_ok <= |hit;
        end
    end
endmodule

/* design/sss_stereo_sync.sv */
// eye indicator, infrared sync and light-encoded sync pulse generation
`timescale 1ns/1ns
module sss_stereo_sync #(
    parameter int unsigned CLK_HZ = sss_pkg::CLK_HZ,
    parameter int unsigned PW = sss_pkg::PERIOD_W,
    parameter int unsigned EYE_LEAD_CYC = sss_pkg::EYE_LEAD_CYC,
    parameter int unsigned B_CYC = sss_pkg::B_CYC,
    parameter int unsigned E_CYC = sss_pkg::E_CYC,
    parameter int unsigned A_NOM_CYC [sss_pkg::NUM_RATES] = sss_pkg::A_NOM_CYC,
    parameter int unsigned D_NOM_CYC [sss_pkg::NUM_RATES] = sss_pkg::D_NOM_CYC
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic vsync,
    input wire logic stereo_en,
    input wire logic light_encoded_sync,
    input wire logic [1:0] pulse_colour,
    input wire logic video_light,
    output logic eye_select,
    output logic ir_sync,
    output logic led_enable,
    output logic [2:0] led_colour,
    output logic sync_pulse,
    output logic rate_ok,
    output logic colour_warn
);
    logic vsync_q;
    logic vsync_rise;
    logic [PW-1:0] period;
    logic [2:0] rate_idx;
    logic [PW-1:0] frame_cnt;
    logic active;
    logic link_on;
    logic alt_long;
    logic frame_left;
    logic [PW-1:0] a_cyc;
    logic [PW-1:0] d_cyc;
    logic [PW-1:0] offset_base;
    logic [PW-1:0] offset_long;
    logic [PW-1:0] offset_cur;
    logic [PW-1:0] pw_cnt;
    logic dark;
    logic next_dark;
    logic pulse_start;
    logic eye_hit;
    sss_pkg::sss_pulse_e pstate;
    sss_pkg::sss_pulse_e next_pstate;

    assign vsync_rise = vsync & ~vsync_q;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            vsync_q <= 1'b0;
        end else begin
            vsync_q <= vsync;
        end
    end

    sss_rate_meter #(
        .CLK_HZ(CLK_HZ),
        .PW(PW)
    ) u_meter (
        .ref_clk(ref_clk),
        .rst(rst),
        .vsync_rise(vsync_rise),
        .period(period),
        .rate_idx(rate_idx),
        .rate_ok(rate_ok)
    );

    // sync only while 3D is requested and rate supported
    assign active = stereo_en & rate_ok;
    assign link_on = active & light_encoded_sync;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            frame_cnt <= '0;
        end else if (vsync_rise) begin
            frame_cnt <= '0;
        end else if (frame_cnt != {PW{1'b1}}) begin
            frame_cnt <= frame_cnt + 1'b1;
        end
    end

    // nominal values reloaded every frame whose rate is supported, so follow rate changes
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            a_cyc <= PW'(A_NOM_CYC[0]);
            d_cyc <= PW'(D_NOM_CYC[0]);
        end else if (vsync_rise && rate_ok) begin
            a_cyc <= PW'(A_NOM_CYC[rate_idx]);
            d_cyc <= PW'(D_NOM_CYC[rate_idx]);
        end
    end

    // long offset is base plus delta
    assign offset_base = PW'(B_CYC);
    assign offset_long = offset_base + d_cyc;
    assign offset_cur = alt_long ? offset_long : offset_base;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            alt_long <= 1'b0;
        end else if (!active) begin
            alt_long <= 1'b0;
        end else if (vsync_rise) begin
            alt_long <= ~alt_long;
        end
    end

    // toggle predicted from last period; a rate jump shifts one frame only
    assign eye_hit = active && (period > PW'(EYE_LEAD_CYC))
        && (frame_cnt == period - PW'(EYE_LEAD_CYC));

    // one means left; left then right of each source frame
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            eye_select <= 1'b0;
        end else if (!active) begin
            eye_select <= 1'b0;
        end else if (eye_hit) begin
            eye_select <= ~eye_select;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            frame_left <= 1'b0;
        end else if (vsync_rise) begin
            frame_left <= eye_select;
        end
    end

    // infrared emitter follows the eye indicator while light-encoded sync is off
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ir_sync <= 1'b0;
        end else begin
            ir_sync <= active & ~light_encoded_sync & (eye_hit ? ~eye_select : eye_select);
        end
    end

    // shutters closed for the last E of the frame
    assign next_dark = link_on && !vsync_rise && (period > PW'(E_CYC))
        && (frame_cnt + 1'b1 >= period - PW'(E_CYC));

    // one start point per frame, inside the dark window
    assign pulse_start = link_on && (period > offset_cur)
        && (frame_cnt == period - offset_cur);

    always_comb begin
        next_pstate = pstate;
        case (pstate)
            sss_pkg::PS_IDLE: begin
                if (pulse_start) begin
                    next_pstate = sss_pkg::PS_PULSE;
                end
            end
            sss_pkg::PS_PULSE: begin
                if (vsync_rise || !link_on || pw_cnt == a_cyc - 1'b1) begin
                    next_pstate = sss_pkg::PS_IDLE;
                end
            end
            default: begin
                next_pstate = sss_pkg::PS_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pstate <= sss_pkg::PS_IDLE;
        end else begin
            pstate <= next_pstate;
        end
    end

    // width counted in cycles of the nominal A
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            pw_cnt <= '0;
        end else if (pstate == sss_pkg::PS_PULSE) begin
            pw_cnt <= pw_cnt + 1'b1;
        end else begin
            pw_cnt <= '0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            dark <= 1'b0;
            sync_pulse <= 1'b0;
            led_enable <= 1'b0;
        end else begin
            dark <= next_dark;
            sync_pulse <= (next_pstate == sss_pkg::PS_PULSE);
            led_enable <= (next_pstate == sss_pkg::PS_PULSE) | (video_light & ~next_dark);
        end
    end

    // pulse colour selectable; blue still honoured but flagged
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            led_colour <= 3'h1;
            colour_warn <= 1'b0;
        end else begin
            colour_warn <= link_on && (pulse_colour == sss_pkg::COL_BLUE);
            case (pulse_colour)
                sss_pkg::COL_GREEN: led_colour <= 3'h2;
                sss_pkg::COL_BLUE: led_colour <= 3'h4;
                default: led_colour <= 3'h1;
            endcase
        end
    end

    // helper: pulses seen in the current frame
    logic [1:0] pulses_in_frame;
    always_ff @(posedge ref_clk) begin
        if (rst || vsync_rise) begin
            pulses_in_frame <= 2'h0;
        end else if (pulse_start && pstate == sss_pkg::PS_IDLE && pulses_in_frame != 2'h3) begin
            pulses_in_frame <= pulses_in_frame + 1'b1;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    sequence s_pulse_begin;
        $rose(sync_pulse);
    endsequence

    sequence s_pulse_end;
        $fell(sync_pulse) && $past(link_on) && !$past(vsync_rise);
    endsequence

    property p_inactive_quiet;
        !active |=> !eye_select && !sync_pulse;
    endproperty
    a_inactive_quiet:
        assert property (p_inactive_quiet) else $error("sync active while 3D off");

    property p_ir_follow;
        ##1 $past(active && !light_encoded_sync) |-> ir_sync == eye_select;
    endproperty
    a_ir_follow:
        assert property (p_ir_follow) else $error("ir sync differs from eye indicator");

    property p_one_pulse;
        vsync_rise |-> pulses_in_frame <= 2'h1;
    endproperty
    a_one_pulse:
        assert property (p_one_pulse) else $error("more than one pulse in a frame");

    property p_pulse_dark;
        s_pulse_begin |-> dark && led_enable;
    endproperty
    a_pulse_dark:
        assert property (p_pulse_dark) else $error("pulse outside dark window");

    property p_led_dark;
        dark && !sync_pulse |-> !led_enable;
    endproperty
    a_led_dark:
        assert property (p_led_dark) else $error("light on while shutters closed");

    property p_colour;
        ##1 $past(pulse_colour == sss_pkg::COL_RED) |-> led_colour == 3'h1;
    endproperty
    a_colour:
        assert property (p_colour) else $error("red selection not on red source");

    property p_frame_left;
        vsync_rise && active |=> frame_left == $past(eye_select);
    endproperty
    a_frame_left:
        assert property (p_frame_left) else $error("frame eye not taken from indicator");

    property p_eye_lead;
        ##1 $changed(eye_select) && $past(active)
            |-> $past(frame_cnt) + PW'(EYE_LEAD_CYC) == $past(period);
    endproperty
    a_eye_lead:
        assert property (p_eye_lead) else $error("eye indicator not one ms ahead");

    property p_alternate;
        vsync_rise && active ##1 active |-> alt_long != $past(alt_long);
    endproperty
    a_alternate:
        assert property (p_alternate) else $error("offset did not alternate");

    property p_width;
        s_pulse_end |-> $past(pw_cnt) + 1'b1 == $past(a_cyc);
    endproperty
    a_width:
        assert property (p_width) else $error("pulse width not nominal A");

    // windows follow the clock rate actually used, so tables scale with it
    localparam longint HZ64 = CLK_HZ;
    localparam longint GIGA = 1_000_000_000;
    localparam int unsigned A_LO = 32'((sss_pkg::A_MIN_NS * HZ64 + GIGA - 1) / GIGA);
    localparam int unsigned A_HI = 32'(sss_pkg::A_MAX_NS * HZ64 / GIGA);
    localparam int unsigned D_LO = 32'((sss_pkg::D_MIN_NS * HZ64 + GIGA - 1) / GIGA);
    localparam int unsigned D_HI = 32'(sss_pkg::D_MAX_NS * HZ64 / GIGA);
    property p_ranges;
        a_cyc >= PW'(A_LO) && a_cyc <= PW'(A_HI)
            && d_cyc >= PW'(D_LO) && d_cyc <= PW'(D_HI);
    endproperty
    a_ranges:
        assert property (p_ranges) else $error("pulse parameter out of window");

    property p_offset;
        s_pulse_begin |-> $past(frame_cnt) + (alt_long ? offset_long : offset_base)
            == $past(period) && offset_long - offset_base == d_cyc;
    endproperty
    a_offset:
        assert property (p_offset) else $error("pulse offset wrong");

    property p_reload;
        vsync_rise && rate_ok |=> a_cyc == PW'(A_NOM_CYC[$past(rate_idx)]);
    endproperty
    a_reload:
        assert property (p_reload) else $error("nominal A not reloaded");
endmodule

/* verif/sss_glasses_model.sv */
// illumination driver and glasses sensor model for the stereo shutter sync bench
`timescale 1ns/1ns
module sss_glasses_model (
    input wire logic ref_clk,
    input wire logic vsync,
    input wire logic led_enable,
    input wire logic [2:0] led_colour,
    output int burst_cnt,
    output int burst_len,
    output int burst_lead,
    output logic [2:0] burst_colour
);
    logic led_q;
    logic vs_q;
    int since;
    int run;

    initial begin
        burst_cnt = 0;
        burst_len = 0;
        burst_lead = 0;
        burst_colour = 3'h0;
        led_q = 1'b0;
        vs_q = 1'b0;
        since = 0;
        run = 0;
    end

    // sensor sees light only while enabled
    always @(posedge ref_clk) begin
        led_q <= led_enable;
        vs_q <= vsync;
        since <= since + 1;
        if (led_enable && !led_q) begin
            burst_cnt <= burst_cnt + 1;
            burst_colour <= led_colour;
            since <= 0;
            run <= 1;
        end else if (led_enable) begin
            run <= run + 1;
        end
        if (!led_enable && led_q) begin
            burst_len <= run;
        end
        // distance from burst start to the next frame start
        if (vsync && !vs_q) begin
            burst_lead <= since;
        end
    end
endmodule

/* verif/sss_stereo_sync_bench.sv */
// self-checking bench for the stereo shutter sync block
`timescale 1ns/1ns
module sss_stereo_sync_bench;
    // block told its clock is a hundred times slower, so a 120 hz frame is short
    localparam int SC = 100;
    localparam int unsigned HZ = sss_pkg::CLK_HZ / SC;
    localparam int RIDX = 4;
    localparam int PER = (HZ + 60) / 120;
    localparam int EL = sss_pkg::EYE_LEAD_CYC / SC;
    localparam int B = (sss_pkg::B_CYC - 1) / SC + 1;
    localparam int E = (sss_pkg::E_CYC - 1) / SC + 1;
    localparam int unsigned A_TAB [sss_pkg::NUM_RATES] = '{
        sss_pkg::A_NOM_CYC[0] / SC, sss_pkg::A_NOM_CYC[1] / SC, sss_pkg::A_NOM_CYC[2] / SC,
        sss_pkg::A_NOM_CYC[3] / SC, sss_pkg::A_NOM_CYC[4] / SC, sss_pkg::A_NOM_CYC[5] / SC};
    localparam int unsigned D_TAB [sss_pkg::NUM_RATES] = '{
        sss_pkg::D_NOM_CYC[0] / SC, sss_pkg::D_NOM_CYC[1] / SC, sss_pkg::D_NOM_CYC[2] / SC,
        sss_pkg::D_NOM_CYC[3] / SC, sss_pkg::D_NOM_CYC[4] / SC, sss_pkg::D_NOM_CYC[5] / SC};
    localparam int A = A_TAB[RIDX];
    localparam int D = D_TAB[RIDX];
    logic ref_clk, rst, vsync, stereo_en, light_encoded_sync, video_light;
    logic [1:0] pulse_colour;
    logic eye_select, ir_sync, led_enable, sync_pulse, rate_ok, colour_warn;
    logic [2:0] led_colour, burst_colour;
    int burst_cnt, burst_len, burst_lead;
    int n_fail = 0;
    int num_checks = 0;
    int per = 1000;
    int fcnt = 0;
    bit vs_on = 1'b0;

    sss_stereo_sync #(
        .CLK_HZ(HZ),
        .EYE_LEAD_CYC(EL),
        .B_CYC(B),
        .E_CYC(E),
        .A_NOM_CYC(A_TAB),
        .D_NOM_CYC(D_TAB)
    ) sss_stereo_sync_inst (
        .ref_clk(ref_clk),
        .rst(rst),
        .vsync(vsync),
        .stereo_en(stereo_en),
        .light_encoded_sync(light_encoded_sync),
        .pulse_colour(pulse_colour),
        .video_light(video_light),
        .eye_select(eye_select),
        .ir_sync(ir_sync),
        .led_enable(led_enable),
        .led_colour(led_colour),
        .sync_pulse(sync_pulse),
        .rate_ok(rate_ok),
        .colour_warn(colour_warn)
    );

    sss_glasses_model sss_glasses_model_inst (
        .ref_clk(ref_clk),
        .vsync(vsync),
        .led_enable(led_enable),
        .led_colour(led_colour),
        .burst_cnt(burst_cnt),
        .burst_len(burst_len),
        .burst_lead(burst_lead),
        .burst_colour(burst_colour)
    );

    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    // frame generator; fcnt counts cycles since the frame began
    always @(posedge ref_clk) begin
        fcnt = (!vs_on || fcnt + 1 >= per) ? 0 : fcnt + 1;
        vsync <= #1 vs_on && (fcnt < 100);
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic step();
        @(posedge ref_clk);
        #1;
    endtask

    task automatic wait_fc(input int f);
        int i;
        step();
        for (i = 0; i < 2 * PER && fcnt != f; i++) step();
        // a frame point that never comes is a mismatch
        if (fcnt != f) n_fail++;
    endtask

    task automatic run_frame(output int lead, output logic pulsed);
        logic last;
        last = eye_select;
        lead = -1;
        pulsed = 1'b0;
        step();
        while (fcnt != 5) begin
            if (eye_select !== last) lead = per + 1 - fcnt;
            last = eye_select;
            pulsed = pulsed | sync_pulse;
            step();
        end
    endtask

    task automatic scen_reset();
        repeat (8) step();
        check({eye_select, ir_sync, led_enable, led_colour, sync_pulse, rate_ok,
            colour_warn}, 9'h008);
        rst = 1'b0;
        step();
        check({eye_select, ir_sync, sync_pulse, rate_ok}, 4'h0);
    endtask

    task automatic scen_refuse();
        logic bad;
        bad = 1'b0;
        stereo_en = 1'b1;
        light_encoded_sync = 1'b1;
        vs_on = 1'b1;
        repeat (3_000) begin
            step();
            bad = bad | rate_ok | eye_select | ir_sync | sync_pulse;
        end
        check(bad, 1'b0);
        vs_on = 1'b0;
    endtask

    task automatic scen_ir();
        int lead;
        logic pulsed, prev;
        light_encoded_sync = 1'b0;
        per = PER;
        step();
        vs_on = 1'b1;
        repeat (3) wait_fc(5);
        check(rate_ok, 1'b1);
        prev = eye_select;
        repeat (2) begin
            run_frame(lead, pulsed);
            check(lead >= EL - 2 && lead <= EL + 2, 1'b1);
            check(eye_select, !prev);
            check(ir_sync, eye_select);
            check(pulsed, 1'b0);
            prev = eye_select;
        end
    endtask

    task automatic scen_le();
        logic [2:0] hue [4] = '{3'h1, 3'h2, 3'h4, 3'h1};
        int lead [4];
        int c0, d, i;
        light_encoded_sync = 1'b1;
        for (i = 0; i < 4; i++) begin
            pulse_colour = i[1:0];
            c0 = burst_cnt;
            wait_fc(PER / 2);
            check(colour_warn, i == 2);
            check(ir_sync, 1'b0);
            wait_fc(5);
            check(burst_cnt - c0, 1);
            check(burst_len, A);
            check(burst_colour, hue[i]);
            lead[i] = burst_lead;
        end
        for (i = 1; i < 4; i++) begin
            d = lead[i] - lead[i - 1];
            check(d < 0 ? -d : d, D);
        end
        d = lead[0] < lead[1] ? lead[0] : lead[1];
        check(d >= B - 3 && d <= B + 3, 1'b1);
    endtask

    task automatic scen_dark();
        video_light = 1'b1;
        pulse_colour = 2'b00;
        wait_fc(PER - 2 * E);
        check(led_enable, 1'b1);
        wait_fc(PER - E / 2);
        check(led_enable, 1'b0);
        wait_fc(5);
        video_light = 1'b0;
    endtask

    task automatic scen_off();
        int c0;
        stereo_en = 1'b0;
        c0 = burst_cnt;
        wait_fc(5);
        check(burst_cnt - c0, 0);
        check({ir_sync, sync_pulse}, 2'b00);
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // about ten frames of PER cycles plus the refused run, with margin
    initial begin
        #(70_000 * 20);
        n_fail++;
        test_done();
    end

    initial begin
        rst = 1'b1;
        vsync = 1'b0;
        stereo_en = 1'b0;
        light_encoded_sync = 1'b0;
        pulse_colour = 2'b00;
        video_light = 1'b0;
        scen_reset();
        scen_refuse();
        scen_ir();
        scen_le();
        scen_dark();
        scen_off();
        test_done();
    end
endmodule
